/* src/stc_defines.vh */
// Purpose: constants for the sense timing and channel configuration block
// Assumes: one 250 MHz clock, byte wide configuration port
// Notes: register index is the byte position inside the two settings groups
`ifndef STC_DEFINES_VH
`define STC_DEFINES_VH

// ==========================================================
// register indexes
`define STC_IDX_STUCK_LIMIT 4'h0
`define STC_IDX_BUS_IDLE 4'h1
`define STC_IDX_MODE_SWITCH 4'h2
`define STC_IDX_LP_SLEEP 4'h3
`define STC_IDX_CYC_SLEEP 4'h4
`define STC_IDX_RX_TOTAL 4'h5
`define STC_IDX_TX_TOTAL 4'h6
`define STC_IDX_XY_RX 4'h7
`define STC_IDX_XY_TX 4'h8
`define STC_IDX_PROX_SETUP 4'h9
`define STC_IDX_TX_MASK_HI 4'hA
`define STC_IDX_TX_MASK_LO 4'hB

// ==========================================================
// reset values
`define STC_RST_STUCK_LIMIT 8'h50
`define STC_RST_BUS_IDLE 8'h64
`define STC_RST_MODE_SWITCH 8'h08
`define STC_RST_LP_SLEEP 8'h08
`define STC_RST_CYC_SLEEP 8'h03
`define STC_RST_RX_TOTAL 8'h0A
`define STC_RST_TX_TOTAL 8'h0F
`define STC_RST_XY_RX 8'h0A
`define STC_RST_XY_TX 8'h0F
`define STC_RST_PROX_SETUP 8'h40
`define STC_RST_TX_MASK_HI 8'h7F
`define STC_RST_TX_MASK_LO 8'hFF

// ==========================================================
// prox_channel_setup fields
`define STC_PS_SELF_BIT 7
`define STC_PS_GROUP_BIT 6
`define STC_PS_COMBINE_BIT 4
`define STC_PS_RXSEL_MSB 3
`define STC_PS_RXSEL_LSB 0
`define STC_RXSEL_MAX 4'h9
`define STC_TXHI_USED_MSB 6

// ==========================================================
// timing
`define STC_CLK_PERIOD_PS 4000
`define STC_TICK_PERIOD_PS 1000000000
`define STC_UNIT_MS 9'h1F4

`endif

/* src/stc_timing_core.v */
// Purpose: timers and channel setup of the sense controller
// Assumes: config writes come from the serial slave on this clock
// Notes:
// Notes on behaviour
// - Prox or touch held longer than the stuck limit forces a reseed.
// - Stuck timeout in normal mode reseeds all channels except proximity.
// - Stuck timeout in proximity only mode reseeds just the proximity channel.
// - Stuck limit counts in 500 ms units; reset value 80 gives 40 s.
// - Host reseed command is honoured at any time, independent of timer.
// - No good bus transfer within idle limit ms closes window, sensing resumes.
// - Data ready stays high at most the idle limit after the last good transfer, then drops.
// - Mode switch interval times mode changes in 500 ms units, reset 8.
// - Low power mode sleeps the low power interval between acquisitions.
// - Cycle sleep is always added to each normal cycle, plus low power.
// - Sleep codes 1 to 13 decode to 1 ms up to 5 s.
// - Readout sizes follow the total and xy receiver and transmitter counts.
// - Setup bit 7 picks mutual (0) or self (1) charging.
// - Setup bit 6 places proximity electrode in group A (0) or B (1).
// - Setup bit 4 sums xy receivers; charging and mask still apply.
// - Setup bits 3..0 pick receiver 0 to 9.
// - Mask bytes enable transmitters 14..0; upper bit 7 unused.
// - Self charging uses the receiver alone and ignores the mask.

`timescale 1ns/1ps
`include "stc_defines.vh"
`default_nettype none

module stc_timing_core #(
  parameter MS_CYCLES = `STC_TICK_PERIOD_PS / `STC_CLK_PERIOD_PS
)(
  input wire mclk_i,
  input wire nrst_i,
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [3:0] cfg_idx_i,
  input wire [7:0] cfg_wdata_i,
  output reg [7:0] cfg_rdata_o,
  input wire touch_any_i,
  input wire proximity_only_mode_i,
  input wire reseed_cmd_i,
  output reg reseed_normal_o,
  output reg reseed_prox_o,
  input wire window_open_i,
  input wire window_end_i,
  input wire bus_xfer_done_i,
  output wire data_ready_line_o,
  output reg window_timeout_o,
  input wire mode_run_i,
  input wire mode_restart_i,
  output reg mode_expire_o,
  input wire sleep_start_i,
  input wire lowpower_mode_i,
  output wire sleep_active_o,
  output reg sleep_done_o,
  output reg prox_self_o,
  output reg prox_group_b_o,
  output reg combine_xy_receivers_o,
  output reg [3:0] prox_rx_sel_o,
  output reg [14:0] prox_transmitter_enable_o,
  output reg [15:0] total_channels_o,
  output reg [15:0] xy_channels_o
);

  // ==========================================================
  // sleep code decode, shared by both sleep selectors
  function [12:0] stc_sleep_ms;
    input [7:0] code;
    begin
      case (code)
        8'h01: stc_sleep_ms = 13'h0001;
        8'h02: stc_sleep_ms = 13'h0002;
        8'h03: stc_sleep_ms = 13'h0005;
        8'h04: stc_sleep_ms = 13'h000A;
        8'h05: stc_sleep_ms = 13'h0014;
        8'h06: stc_sleep_ms = 13'h0028;
        8'h07: stc_sleep_ms = 13'h0050;
        8'h08: stc_sleep_ms = 13'h00A0;
        8'h09: stc_sleep_ms = 13'h0140;
        8'h0A: stc_sleep_ms = 13'h0280;
        8'h0B: stc_sleep_ms = 13'h04B0;
        8'h0C: stc_sleep_ms = 13'h0960;
        8'h0D: stc_sleep_ms = 13'h1388;
        default: stc_sleep_ms = 13'h0000;
      endcase
    end
  endfunction

  // ==========================================================
  // half second units to milliseconds, shared by two timers
  function [16:0] stc_half_sec_ms;
    input [7:0] units;
    begin
      stc_half_sec_ms = units * `STC_UNIT_MS;
    end
  endfunction

  // ==========================================================
  // configuration registers
  reg [7:0] stuck_limit_q;
  reg [7:0] bus_idle_q;
  reg [7:0] mode_switch_q;
  reg [7:0] lp_sleep_q;
  reg [7:0] cyc_sleep_q;
  reg [7:0] rx_total_q;
  reg [7:0] tx_total_q;
  reg [7:0] xy_rx_q;
  reg [7:0] xy_tx_q;
  reg [7:0] prox_setup_q;
  reg [7:0] mask_hi_q;
  reg [7:0] mask_lo_q;
  reg [7:0] rdata_d;

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stuck_limit_q <= `STC_RST_STUCK_LIMIT;
      bus_idle_q <= `STC_RST_BUS_IDLE;
      mode_switch_q <= `STC_RST_MODE_SWITCH;
      lp_sleep_q <= `STC_RST_LP_SLEEP;
      cyc_sleep_q <= `STC_RST_CYC_SLEEP;
      rx_total_q <= `STC_RST_RX_TOTAL;
      tx_total_q <= `STC_RST_TX_TOTAL;
      xy_rx_q <= `STC_RST_XY_RX;
      xy_tx_q <= `STC_RST_XY_TX;
      prox_setup_q <= `STC_RST_PROX_SETUP;
      mask_hi_q <= `STC_RST_TX_MASK_HI;
      mask_lo_q <= `STC_RST_TX_MASK_LO;
    end
    // derived outputs follow a write one cycle later
    else if (cfg_wr_i)
    begin
      case (cfg_idx_i)
        `STC_IDX_STUCK_LIMIT: stuck_limit_q <= cfg_wdata_i;
        `STC_IDX_BUS_IDLE: bus_idle_q <= cfg_wdata_i;
        `STC_IDX_MODE_SWITCH: mode_switch_q <= cfg_wdata_i;
        `STC_IDX_LP_SLEEP: lp_sleep_q <= cfg_wdata_i;
        `STC_IDX_CYC_SLEEP: cyc_sleep_q <= cfg_wdata_i;
        `STC_IDX_RX_TOTAL: rx_total_q <= cfg_wdata_i;
        `STC_IDX_TX_TOTAL: tx_total_q <= cfg_wdata_i;
        `STC_IDX_XY_RX: xy_rx_q <= cfg_wdata_i;
        `STC_IDX_XY_TX: xy_tx_q <= cfg_wdata_i;
        `STC_IDX_PROX_SETUP: prox_setup_q <= cfg_wdata_i;
        // upper bit has no transmitter behind it
        `STC_IDX_TX_MASK_HI: mask_hi_q <= {1'b0, cfg_wdata_i[`STC_TXHI_USED_MSB:0]};
        `STC_IDX_TX_MASK_LO: mask_lo_q <= cfg_wdata_i;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // register read port; unmapped indexes read as zero
  always @*
  begin
    case (cfg_idx_i)
      `STC_IDX_STUCK_LIMIT: rdata_d = stuck_limit_q;
      `STC_IDX_BUS_IDLE: rdata_d = bus_idle_q;
      `STC_IDX_MODE_SWITCH: rdata_d = mode_switch_q;
      `STC_IDX_LP_SLEEP: rdata_d = lp_sleep_q;
      `STC_IDX_CYC_SLEEP: rdata_d = cyc_sleep_q;
      `STC_IDX_RX_TOTAL: rdata_d = rx_total_q;
      `STC_IDX_TX_TOTAL: rdata_d = tx_total_q;
      `STC_IDX_XY_RX: rdata_d = xy_rx_q;
      `STC_IDX_XY_TX: rdata_d = xy_tx_q;
      `STC_IDX_PROX_SETUP: rdata_d = prox_setup_q;
      `STC_IDX_TX_MASK_HI: rdata_d = mask_hi_q;
      `STC_IDX_TX_MASK_LO: rdata_d = mask_lo_q;
      default: rdata_d = 8'h00;
    endcase
  end

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      cfg_rdata_o <= 8'h00;
    else if (cfg_rd_i)
      cfg_rdata_o <= rdata_d;
  end

  // ==========================================================
  // millisecond time base
  reg [31:0] pre_q;
  wire ms_tick;

  // one shared tick: a timer may fire up to one tick early
  assign ms_tick = (pre_q == MS_CYCLES - 1);

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      pre_q <= 32'h0000_0000;
    else if (ms_tick)
      pre_q <= 32'h0000_0000;
    else
      pre_q <= pre_q + 32'h0000_0001;
  end

  // ==========================================================
  // stuck indication timer
  reg [16:0] stuck_ms_q;
  wire [16:0] stuck_lim_ms;
  wire stuck_hit;
  wire reseed_now;

  assign stuck_lim_ms = stc_half_sec_ms(stuck_limit_q);
  // zero limit disables the automatic reseed
  assign stuck_hit = touch_any_i && (stuck_limit_q != 8'h00) && (stuck_ms_q >= stuck_lim_ms);
  assign reseed_now = stuck_hit || reseed_cmd_i;

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      stuck_ms_q <= 17'h00000;
    else if (!touch_any_i || reseed_now)
      stuck_ms_q <= 17'h00000;
    else if (ms_tick && !stuck_hit)
      stuck_ms_q <= stuck_ms_q + 17'h00001;
  end

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      reseed_normal_o <= 1'b0;
      reseed_prox_o <= 1'b0;
    end
    else
    begin
      reseed_normal_o <= reseed_now && !proximity_only_mode_i;
      reseed_prox_o <= reseed_now && proximity_only_mode_i;
    end
  end

  // ==========================================================
  // communication window and ready line
  reg window_q;
  reg [7:0] idle_ms_q;
  wire idle_hit;

  // a transfer in the limit cycle keeps the window open
  assign idle_hit = window_q && (idle_ms_q >= bus_idle_q) && !bus_xfer_done_i;
  assign data_ready_line_o = window_q;

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      window_q <= 1'b0;
      idle_ms_q <= 8'h00;
      window_timeout_o <= 1'b0;
    end
    else
    begin
      window_timeout_o <= idle_hit;
      if (window_open_i && !window_q)
      begin
        window_q <= 1'b1;
        idle_ms_q <= 8'h00;
      end
      else if (window_end_i || idle_hit)
        window_q <= 1'b0;
      else if (bus_xfer_done_i)
        idle_ms_q <= 8'h00;
      else if (window_q && ms_tick)
        idle_ms_q <= idle_ms_q + 8'h01;
    end
  end

  // ==========================================================
  // mode switch timer
  // wide enough for 255 units of 500 ms, the longest limit
  reg [16:0] mode_ms_q;
  wire [16:0] mode_lim_ms;
  wire mode_hit;

  assign mode_lim_ms = stc_half_sec_ms(mode_switch_q);
  assign mode_hit = mode_run_i && !mode_restart_i && (mode_ms_q >= mode_lim_ms);

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mode_ms_q <= 17'h00000;
      mode_expire_o <= 1'b0;
    end
    else
    begin
      mode_expire_o <= mode_hit;
      if (mode_restart_i || mode_hit || !mode_run_i)
        mode_ms_q <= 17'h00000;
      else if (ms_tick)
        mode_ms_q <= mode_ms_q + 17'h00001;
    end
  end

  // ==========================================================
  // cycle sleep; low power interval is added on top when requested
  reg [13:0] sleep_ms_q;
  wire [12:0] cyc_ms;
  wire [12:0] lp_ms;
  wire [13:0] sleep_load;

  assign cyc_ms = stc_sleep_ms(cyc_sleep_q);
  assign lp_ms = lowpower_mode_i ? stc_sleep_ms(lp_sleep_q) : 13'h0000;
  // both parts at their longest still fit, so the sum never wraps
  assign sleep_load = {1'b0, cyc_ms} + {1'b0, lp_ms};
  assign sleep_active_o = (sleep_ms_q != 14'h0000);

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sleep_ms_q <= 14'h0000;
      sleep_done_o <= 1'b0;
    end
    else
    begin
      sleep_done_o <= 1'b0;
      // a start while asleep is ignored rather than stretching the interval
      if (sleep_start_i && !sleep_active_o)
      begin
        sleep_ms_q <= sleep_load;
        // nothing to wait for: report completion at once
        sleep_done_o <= (sleep_load == 14'h0000);
      end
      else if (sleep_active_o && ms_tick)
      begin
        sleep_ms_q <= sleep_ms_q - 14'h0001;
        sleep_done_o <= (sleep_ms_q == 14'h0001);
      end
    end
  end

  // ==========================================================
  // proximity channel and readout sizing
  wire self_sel;
  wire [3:0] rx_field;
  wire [14:0] mask_word;

  assign self_sel = prox_setup_q[`STC_PS_SELF_BIT];
  assign rx_field = prox_setup_q[`STC_PS_RXSEL_MSB:`STC_PS_RXSEL_LSB];
  assign mask_word = {mask_hi_q[`STC_TXHI_USED_MSB:0], mask_lo_q};

  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prox_self_o <= 1'b0;
      prox_group_b_o <= 1'b0;
      combine_xy_receivers_o <= 1'b0;
      prox_rx_sel_o <= 4'h0;
      prox_transmitter_enable_o <= 15'h0000;
      total_channels_o <= 16'h0000;
      xy_channels_o <= 16'h0000;
    end
    else
    begin
      prox_self_o <= self_sel;
      prox_group_b_o <= prox_setup_q[`STC_PS_GROUP_BIT];
      combine_xy_receivers_o <= prox_setup_q[`STC_PS_COMBINE_BIT];
      // out of range indexes clamp to the last receiver
      prox_rx_sel_o <= (rx_field > `STC_RXSEL_MAX) ? `STC_RXSEL_MAX : rx_field;
      prox_transmitter_enable_o <= self_sel ? 15'h0000 : mask_word;
      total_channels_o <= rx_total_q * tx_total_q;
      xy_channels_o <= xy_rx_q * xy_tx_q;
    end
  end

endmodule // stc_timing_core

`default_nettype wire

/* bench/stc_timing_monitor.sv */
// Purpose: port checks for stc_timing_core
// Assumes: one clock, asynchronous active low reset
// Notes: idle limit is shadowed from config writes seen at the port
`timescale 1ns/1ps
`default_nettype none
module stc_timing_monitor #(
  parameter int MS_CYCLES = 4
)(
  input wire logic mclk_i,
  input wire logic nrst_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [3:0] cfg_idx_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic [7:0] cfg_rdata_o,
  input wire logic touch_any_i,
  input wire logic proximity_only_mode_i,
  input wire logic reseed_cmd_i,
  input wire logic reseed_normal_o,
  input wire logic reseed_prox_o,
  input wire logic window_open_i,
  input wire logic bus_xfer_done_i,
  input wire logic data_ready_line_o,
  input wire logic window_timeout_o,
  input wire logic sleep_start_i,
  input wire logic sleep_active_o,
  input wire logic sleep_done_o,
  input wire logic prox_self_o,
  input wire logic [3:0] prox_rx_sel_o,
  input wire logic [14:0] prox_transmitter_enable_o
);
  // ==========================================================
  // helpers
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] idle_q;
  int rdy_q;
  // ready time since last good transfer, bounded by the idle limit plus tick slack
  always @(posedge mclk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      idle_q <= 8'h64;
      rdy_q <= 0;
    end
    else
    begin
      if (cfg_wr_i && cfg_idx_i == 4'h1) idle_q <= cfg_wdata_i;
      rdy_q <= (data_ready_line_o && !bus_xfer_done_i) ? rdy_q + 1 : 0;
    end
  end
  // ==========================================================
  // assertions
  cmd_normal_a: assert property (reseed_cmd_i && !proximity_only_mode_i |=> reseed_normal_o && !reseed_prox_o)
    else $error("host reseed in normal mode not routed");
  cmd_prox_a: assert property (reseed_cmd_i && proximity_only_mode_i |=> reseed_prox_o && !reseed_normal_o)
    else $error("host reseed in proximity mode not routed");
  reseed_cause_a: assert property (reseed_normal_o || reseed_prox_o |-> $past(reseed_cmd_i) || $past(touch_any_i))
    else $error("reseed without command or held touch");
  reseed_route_a: assert property (reseed_prox_o |-> $past(proximity_only_mode_i))
    else $error("proximity reseed outside proximity mode");
  ready_open_a: assert property (window_open_i && !data_ready_line_o |=> data_ready_line_o)
    else $error("ready line not raised on window open");
  timeout_low_a: assert property (window_timeout_o |-> !data_ready_line_o)
    else $error("ready line high at window timeout");
  ready_bound_a: assert property (rdy_q <= idle_q * MS_CYCLES + 2 * MS_CYCLES + 2)
    else $error("ready line held past idle limit");
  rdata_hold_a: assert property (!cfg_rd_i |=> $stable(cfg_rdata_o))
    else $error("read data changed without read");
  self_mask_a: assert property (prox_self_o |-> prox_transmitter_enable_o == 15'h0000)
    else $error("transmitters enabled under self charging");
  rxsel_range_a: assert property (prox_rx_sel_o <= 4'h9)
    else $error("receiver select above nine");
  sleep_start_a: assert property (sleep_start_i && !sleep_active_o |=> sleep_active_o || sleep_done_o)
    else $error("sleep start not taken");
  auto_reseed_c: cover property (reseed_normal_o && !$past(reseed_cmd_i));
  timeout_c: cover property (window_timeout_o);
  sleep_done_c: cover property (sleep_done_o);
endmodule // stc_timing_monitor
bind stc_timing_core stc_timing_monitor #(.MS_CYCLES(MS_CYCLES)) mon (.mclk_i(mclk_i), .nrst_i(nrst_i),
  .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_idx_i(cfg_idx_i), .cfg_wdata_i(cfg_wdata_i),
  .cfg_rdata_o(cfg_rdata_o), .touch_any_i(touch_any_i), .proximity_only_mode_i(proximity_only_mode_i),
  .reseed_cmd_i(reseed_cmd_i), .reseed_normal_o(reseed_normal_o), .reseed_prox_o(reseed_prox_o),
  .window_open_i(window_open_i), .bus_xfer_done_i(bus_xfer_done_i), .data_ready_line_o(data_ready_line_o),
  .window_timeout_o(window_timeout_o), .sleep_start_i(sleep_start_i), .sleep_active_o(sleep_active_o),
  .sleep_done_o(sleep_done_o), .prox_self_o(prox_self_o), .prox_rx_sel_o(prox_rx_sel_o),
  .prox_transmitter_enable_o(prox_transmitter_enable_o));
`default_nettype wire

/* bench/stc_host_model.sv */
// Purpose: host side of the configuration port
// Assumes: strobes are one cycle, taken on the rising edge
// Notes: read data is picked up just after the edge that loads it
`timescale 1ns/1ps
`default_nettype none
module stc_host_model (
  input wire logic mclk_i,
  output logic cfg_wr_o,
  output logic cfg_rd_o,
  output logic [3:0] cfg_idx_o,
  output logic [7:0] cfg_wdata_o,
  input wire logic [7:0] cfg_rdata_i
);
  // ==========================================================
  // access tasks
  initial
  begin
    cfg_wr_o = 1'b0;
    cfg_rd_o = 1'b0;
    cfg_idx_o = 4'h0;
    cfg_wdata_o = 8'h00;
  end
  task automatic wr(input logic [3:0] idx, input logic [7:0] dat);
    @(posedge mclk_i);
    cfg_wr_o <= 1'b1;
    cfg_idx_o <= idx;
    cfg_wdata_o <= dat;
    @(posedge mclk_i);
    cfg_wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [7:0] dat);
    @(posedge mclk_i);
    cfg_rd_o <= 1'b1;
    cfg_idx_o <= idx;
    @(posedge mclk_i);
    cfg_rd_o <= 1'b0;
    #1;
    dat = cfg_rdata_i;
  endtask
endmodule // stc_host_model
`default_nettype wire

/* bench/test_sense_timing_channel_config.sv */
// Purpose: self-checking bench for stc_timing_core
// Assumes: 1 ms tick shortened to MS clock cycles
// Notes: timer checks allow one tick of phase slack
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; \
  $display("FAIL t=%0t got=%0h exp=%0h", $time, a, b); end end
module test_sense_timing_channel_config;
  // ==========================================================
  // signals
  localparam int MS = 4;
  logic mclk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic touch = 1'b0, pmode = 1'b0, mrun = 1'b0, lpm = 1'b0;
  logic [5:0] pl = 6'h00;
  wire cfg_wr, cfg_rd, rs_n, rs_p, rdy, wto, mexp, sact, sdone, pself, pgrp, pcomb;
  wire [3:0] cfg_idx, rxsel;
  wire [7:0] cfg_wd, cfg_rdata;
  wire [14:0] txen;
  wire [15:0] tot, xy;
  wire [4:0] ev = {sdone, mexp, wto, rs_p, rs_n};
  int error_cnt = 0, n_checks = 0, cyc = 0, n;
  logic [7:0] d;
  logic [7:0] rst_tab [12] = '{8'h50, 8'h64, 8'h08, 8'h08, 8'h03, 8'h0A, 8'h0F, 8'h0A, 8'h0F, 8'h40, 8'h7F, 8'hFF};
  int ms_tab [13] = '{1, 2, 5, 10, 20, 40, 80, 160, 320, 640, 1200, 2400, 5000};
  always #2 mclk_i = ~mclk_i;
  stc_host_model host (.mclk_i(mclk_i), .cfg_wr_o(cfg_wr), .cfg_rd_o(cfg_rd), .cfg_idx_o(cfg_idx),
    .cfg_wdata_o(cfg_wd), .cfg_rdata_i(cfg_rdata));
  stc_timing_core #(.MS_CYCLES(MS)) dut (.mclk_i(mclk_i), .nrst_i(nrst_i), .cfg_wr_i(cfg_wr), .cfg_rd_i(cfg_rd),
    .cfg_idx_i(cfg_idx), .cfg_wdata_i(cfg_wd), .cfg_rdata_o(cfg_rdata), .touch_any_i(touch),
    .proximity_only_mode_i(pmode), .reseed_cmd_i(pl[0]), .reseed_normal_o(rs_n), .reseed_prox_o(rs_p),
    .window_open_i(pl[1]), .window_end_i(pl[2]), .bus_xfer_done_i(pl[3]), .data_ready_line_o(rdy),
    .window_timeout_o(wto), .mode_run_i(mrun), .mode_restart_i(pl[4]), .mode_expire_o(mexp),
    .sleep_start_i(pl[5]), .lowpower_mode_i(lpm), .sleep_active_o(sact), .sleep_done_o(sdone),
    .prox_self_o(pself), .prox_group_b_o(pgrp), .combine_xy_receivers_o(pcomb), .prox_rx_sel_o(rxsel),
    .prox_transmitter_enable_o(txen), .total_channels_o(tot), .xy_channels_o(xy));
  // ==========================================================
  // tasks
  task automatic pulse(input int w);
    @(posedge mclk_i) pl[w] <= 1'b1;
    @(posedge mclk_i) pl[w] <= 1'b0;
  endtask
  task automatic waitp(input int w, input int lim);
    n = 0;
    do
    begin
      @(posedge mclk_i);
      #1;
      n++;
    end while (ev[w] !== 1'b1 && n <= lim);
  endtask
  task end_of_test;
    $display("mismatches %0d comparisons %0d", error_cnt, n_checks);
    if (error_cnt == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // hang guard, well above the summed timer runs
  always @(posedge mclk_i)
  begin
    cyc++;
    if (cyc == 60000)
    begin
      error_cnt++;
      end_of_test;
    end
  end
  // ==========================================================
  // sequence
  initial
  begin
    repeat (10) @(posedge mclk_i);
    nrst_i <= 1'b1;
    @(posedge mclk_i);
    #1;
    `CHK({pgrp, txen, tot, xy}, {1'b1, 15'h7FFF, 16'h0096, 16'h0096})
    for (int i = 0; i < 12; i++)
    begin
      host.rd(4'(i), d);
      `CHK(d, rst_tab[i])
    end
    host.wr(4'hC, 8'h5A);
    host.rd(4'hC, d);
    `CHK(d, 8'h00)
    host.wr(4'hA, 8'hFF);
    host.rd(4'hA, d);
    `CHK(d, 8'h7F)
    host.wr(4'hB, 8'h01);
    host.wr(4'hA, 8'h40);
    host.wr(4'h9, 8'h13);
    @(posedge mclk_i);
    #1;
    `CHK({pself, pgrp, pcomb, rxsel, txen}, {3'h1, 4'h3, 15'h4001})
    host.wr(4'h9, 8'hCF);
    host.wr(4'h5, 8'h04);
    host.wr(4'h6, 8'h03);
    host.wr(4'h7, 8'h02);
    host.wr(4'h8, 8'h03);
    @(posedge mclk_i);
    #1;
    `CHK({pself, pgrp, pcomb, rxsel, txen}, {3'h6, 4'h9, 15'h0000})
    `CHK({tot, xy}, {16'h000C, 16'h0006})
    for (int m = 0; m < 2; m++)
    begin
      @(posedge mclk_i) pmode <= m[0];
      pulse(0);
      // reseed outputs stand for one cycle only
      #1;
      `CHK({rs_n, rs_p}, m ? 2'h1 : 2'h2)
    end
    host.wr(4'h0, 8'h01);
    pmode <= 1'b0;
    touch <= 1'b1;
    waitp(0, 1500);
    `CHK(n > 1500, 1'b1)
    @(posedge mclk_i) touch <= 1'b0;
    @(posedge mclk_i) touch <= 1'b1;
    waitp(0, 2100);
    `CHK(n inside {[1990:2010]}, 1'b1)
    waitp(0, 2100);
    `CHK(n inside {[1990:2010]}, 1'b1)
    @(posedge mclk_i) pmode <= 1'b1;
    waitp(1, 2100);
    `CHK(n inside {[1985:2010]}, 1'b1)
    @(posedge mclk_i) touch <= 1'b0;
    host.wr(4'h1, 8'h03);
    pulse(1);
    @(posedge mclk_i);
    #1;
    `CHK(rdy, 1'b1)
    repeat (5)
    begin
      repeat (4) @(posedge mclk_i);
      pulse(3);
    end
    #1;
    `CHK(rdy, 1'b1)
    waitp(2, 40);
    `CHK({rdy, n inside {[6:16]}}, 2'h1)
    pulse(1);
    #1;
    `CHK(rdy, 1'b1)
    pulse(2);
    #1;
    `CHK({rdy, wto}, 2'h0)
    host.wr(4'h2, 8'h01);
    mrun <= 1'b1;
    pulse(4);
    waitp(3, 2100);
    `CHK(n inside {[1990:2010]}, 1'b1)
    for (int c = 1; c <= 13; c++)
    begin
      host.wr(4'h4, 8'(c));
      pulse(5);
      #1;
      `CHK(sact, 1'b1)
      waitp(4, 21000);
      `CHK({sact, n inside {[ms_tab[c-1]*MS-4:ms_tab[c-1]*MS+6]}}, 2'h1)
    end
    host.wr(4'h4, 8'h01);
    host.wr(4'h3, 8'h02);
    lpm <= 1'b1;
    pulse(5);
    waitp(4, 100);
    `CHK(n inside {[3*MS-4:3*MS+6]}, 1'b1)
    end_of_test;
  end
endmodule // test_sense_timing_channel_config
`default_nettype wire
